// ===== design/irqen_consts.vh
/*
 Constants of the interrupt request and enable block: register
 addresses, bit positions, reset values.
 Assumes inclusion by bare name from the block's design files.
*/
`ifndef IRQEN_CONSTS_VH
`define IRQEN_CONSTS_VH

// Register addresses on the special function bus
`define IRQEN_ADDR_REQ 8'hc0
`define IRQEN_ADDR_EN  8'ha8

// Request register bit positions
`define IRQEN_BIT_EXT6   5
`define IRQEN_BIT_T2OVF  6
`define IRQEN_BIT_T2RLD  7

// Enable register bit positions
`define IRQEN_BIT_EX0  0
`define IRQEN_BIT_ET0  1
`define IRQEN_BIT_EX1  2
`define IRQEN_BIT_ET1  3
`define IRQEN_BIT_ES   4
`define IRQEN_BIT_ET2  5
`define IRQEN_BIT_WDT  6
`define IRQEN_BIT_EAL  7

// Reset values
`define IRQEN_REQ_RST 3'h0
`define IRQEN_EN_RST  8'h00

`endif

// ===== design/irqen_sync.v
/*
 Two flip-flop synchroniser with a registered falling and rising
 edge pulse behind it.
 Assumes an asynchronous level input and the block clock.
*/
`timescale 1ns/1ps
module irqen_sync
(
	// Clock and reset
	input  wire clock_in,
	input  wire rst_in,
	// Asynchronous level
	input  wire level_in,
	// Synchronised level and edge pulses
	output reg  level_out,
	output reg  fall_out,
	output reg  rise_out
);
	reg meta_reg;
	reg sync_reg;

	// Two stages, then an edge detector on the second stage only
	always @(posedge clock_in)
	begin
		if (rst_in)
		begin
			meta_reg  <= 1'b1;
			sync_reg  <= 1'b1;
			level_out <= 1'b1;
			fall_out  <= 1'b0;
			rise_out  <= 1'b0;
		end
		else
		begin
			meta_reg  <= level_in;
			sync_reg  <= meta_reg;
			level_out <= sync_reg;
			fall_out  <= level_out & ~sync_reg;
			rise_out  <= ~level_out & sync_reg;
		end
	end
endmodule

// ===== design/irqen_top.v
/*
 Interrupt request flags (external 6 edge, timer 2 overflow, timer 2
 reload) and the first interrupt enable register, with the gated
 per-source requests the core's vectoring logic reads.
 Assumes: a core bus with one-cycle read and write strobes, events
 from timer and compare logic on the same clock, and three external
 pins that are asynchronous.
*/
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "irqen_consts.vh"
module irqen_top
(
	// Clock and reset
	input  wire       clock_in,
	input  wire       rst_in,
	// Register port
	input  wire [7:0] addr_in,
	input  wire [7:0] wdata_in,
	input  wire       wr_in,
	input  wire       rd_in,
	output reg  [7:0] rdata_out,
	// Pins
	input  wire       ext_input_a_in,
	input  wire       timer2_reload_pin_in,
	input  wire       ext6_rising_sel_in,
	// Events from same-clock logic
	input  wire       compare_channel3_in,
	input  wire       timer2_overflow_in,
	input  wire       timer2_reload_pin_enable_in,
	// Raw requests of sources held elsewhere
	input  wire       ext_int0_req_in,
	input  wire       timer0_req_in,
	input  wire       ext_int1_req_in,
	input  wire       timer1_req_in,
	input  wire       serial_req_in,
	// Service acknowledge of the external 6 vector
	input  wire       ext6_ack_in,
	// Gated requests to the core, and the ungated external 6 flag
	output reg        ext_int0_irq_out,
	output reg        timer0_irq_out,
	output reg        ext_int1_irq_out,
	output reg        timer1_irq_out,
	output reg        serial_irq_out,
	output reg        timer2_irq_out,
	output reg        ext6_flag_out,
	// Watchdog restart pulse
	output reg        watchdog_restart_out,
	// Reload happened on the pin
	output reg        timer2_reload_out
);
	// Request flags and enables
	reg        ext_ext_input_a_edge_flag_reg;
	reg        timer2_overflow_flag_reg;
	reg        timer2_reload_request_flag_reg;
	reg  [7:0] interrupt_enable_first_reg;
	reg        ext_ext_input_a_edge_flag_next;
	reg        timer2_overflow_flag_next;
	reg        timer2_reload_request_flag_next;
	reg  [7:0] interrupt_enable_first_next;

	// Synchronised pin edges
	wire       ext6_fall;
	wire       ext6_rise;
	wire       reload_fall;
	reg  [1:0] ext6_sel_sync_reg;

	// Decode helpers
	wire       wr_req;
	wire       wr_en;
	wire       ext6_event;
	wire       reload_event;
	wire       global_int_enable;

	// Address match, used for reads and writes
	function hit;
		input [7:0] addr;
		input [7:0] reg_addr;
		begin
			hit = (addr == reg_addr);
		end
	endfunction

	// External 6 pin synchroniser with edge detection
	irqen_sync ext6_sync
	(
		.clock_in  (clock_in),
		.rst_in    (rst_in),
		.level_in  (ext_input_a_in),
		.level_out (),
		.fall_out  (ext6_fall),
		.rise_out  (ext6_rise)
	);

	// Reload pin synchroniser, falling edge only used
	irqen_sync reload_sync
	(
		.clock_in  (clock_in),
		.rst_in    (rst_in),
		.level_in  (timer2_reload_pin_in),
		.level_out (),
		.fall_out  (reload_fall),
		.rise_out  ()
	);

	// Edge select strap is a pin, synchronise it
	always @(posedge clock_in)
	begin
		if (rst_in)
			ext6_sel_sync_reg <= 2'h0;
		else
			ext6_sel_sync_reg <= {ext6_sel_sync_reg[0], ext6_rising_sel_in};
	end

	assign wr_req = wr_in & hit(addr_in, `IRQEN_ADDR_REQ);
	assign wr_en  = wr_in & hit(addr_in, `IRQEN_ADDR_EN);
	assign global_int_enable    = interrupt_enable_first_reg[`IRQEN_BIT_EAL];

	// Qualifying pin edge or compare match
	assign ext6_event = (ext6_sel_sync_reg[1] ? ext6_rise : ext6_fall)
		| compare_channel3_in;
	// Reload only counts while the reload pin is enabled
	assign reload_event = reload_fall & timer2_reload_pin_enable_in;

	// Flag next values: write first, hardware set wins over clear
	always @*
	begin
		ext_ext_input_a_edge_flag_next         = ext_ext_input_a_edge_flag_reg;
		timer2_overflow_flag_next       = timer2_overflow_flag_reg;
		timer2_reload_request_flag_next = timer2_reload_request_flag_reg;
		if (wr_req)
		begin
			ext_ext_input_a_edge_flag_next =
				wdata_in[`IRQEN_BIT_EXT6];
			timer2_overflow_flag_next =
				wdata_in[`IRQEN_BIT_T2OVF];
			timer2_reload_request_flag_next =
				wdata_in[`IRQEN_BIT_T2RLD];
		end
		// Servicing clears the edge flag
		if (ext6_ack_in)
			ext_ext_input_a_edge_flag_next = 1'b0;
		// Same-cycle hardware events override the write
		if (ext6_event)
			ext_ext_input_a_edge_flag_next = 1'b1;
		if (timer2_overflow_in)
			timer2_overflow_flag_next = 1'b1;
		if (reload_event)
			timer2_reload_request_flag_next = 1'b1;
	end

	// Enable register next value
	always @*
	begin
		interrupt_enable_first_next = interrupt_enable_first_reg;
		if (wr_en)
			interrupt_enable_first_next = wdata_in;
	end

	// State registers
	always @(posedge clock_in)
	begin
		if (rst_in)
		begin
			ext_ext_input_a_edge_flag_reg         <= 1'b0;
			timer2_overflow_flag_reg       <= 1'b0;
			timer2_reload_request_flag_reg <= 1'b0;
			interrupt_enable_first_reg     <= `IRQEN_EN_RST;
		end
		else
		begin
			ext_ext_input_a_edge_flag_reg         <= ext_ext_input_a_edge_flag_next;
			timer2_overflow_flag_reg       <= timer2_overflow_flag_next;
			timer2_reload_request_flag_reg <=
				timer2_reload_request_flag_next;
			// Restart bit is a command, it reads back as zero
			interrupt_enable_first_reg <= interrupt_enable_first_next
				& ~(8'h01 << `IRQEN_BIT_WDT);
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always @(posedge clock_in)
	begin
		if (rst_in)
			rdata_out <= 8'h00;
		else if (rd_in && hit(addr_in, `IRQEN_ADDR_REQ))
			rdata_out <= {timer2_reload_request_flag_reg,
				timer2_overflow_flag_reg,
				ext_ext_input_a_edge_flag_reg, 5'h00};
		else if (rd_in && hit(addr_in, `IRQEN_ADDR_EN))
			rdata_out <= interrupt_enable_first_reg;
		else
			rdata_out <= 8'h00;
	end

	// Gated requests behind the global enable, except the external 6 flag; restart and reload pulses ungated
	always @(posedge clock_in)
	begin
		if (rst_in)
		begin
			ext_int0_irq_out     <= 1'b0;
			timer0_irq_out       <= 1'b0;
			ext_int1_irq_out     <= 1'b0;
			timer1_irq_out       <= 1'b0;
			serial_irq_out       <= 1'b0;
			timer2_irq_out       <= 1'b0;
			ext6_flag_out        <= 1'b0;
			watchdog_restart_out <= 1'b0;
			timer2_reload_out    <= 1'b0;
		end
		else
		begin
			ext_int0_irq_out <= global_int_enable & ext_int0_req_in
				& interrupt_enable_first_reg[`IRQEN_BIT_EX0];
			timer0_irq_out <= global_int_enable & timer0_req_in
				& interrupt_enable_first_reg[`IRQEN_BIT_ET0];
			ext_int1_irq_out <= global_int_enable & ext_int1_req_in
				& interrupt_enable_first_reg[`IRQEN_BIT_EX1];
			timer1_irq_out <= global_int_enable & timer1_req_in
				& interrupt_enable_first_reg[`IRQEN_BIT_ET1];
			serial_irq_out <= global_int_enable & serial_req_in
				& interrupt_enable_first_reg[`IRQEN_BIT_ES];
			timer2_irq_out <= global_int_enable
				& interrupt_enable_first_reg[`IRQEN_BIT_ET2]
				& (timer2_overflow_flag_reg
				| timer2_reload_request_flag_reg);
			ext6_flag_out <= ext_ext_input_a_edge_flag_reg;
			// One pulse per write with the restart bit set
			watchdog_restart_out <= wr_en
				& wdata_in[`IRQEN_BIT_WDT];
			timer2_reload_out <= reload_event;
		end
	end
endmodule

// ===== verification/irqen_core_model.sv
/* Core model: acknowledges the external 6 flag after a delay.
 Assumes the block's clock and synchronous reset. */
`timescale 1ns/1ps
module irqen_core_model
(
	// Clock, reset, service control
	input  logic       clock_in,
	input  logic       rst_in,
	input  logic       service_en_in,
	input  logic [3:0] delay_in,
	// Flag in, acknowledge out
	input  logic       ext6_flag_in,
	output logic       ext6_ack_out
);
	logic [3:0] wait_reg;
	// Count the delay, then pulse one acknowledge
	always @(posedge clock_in)
	begin
		if (rst_in || !ext6_flag_in || !service_en_in || ext6_ack_out)
		begin
			wait_reg <= 4'h0;
			ext6_ack_out <= 1'b0;
		end
		else if (wait_reg == delay_in)
			ext6_ack_out <= 1'b1;
		else
			wait_reg <= wait_reg + 4'h1;
	end
endmodule

// ===== verification/irqen_properties.sv
/* Port checker of the request and enable block.
 Assumes a bind to irqen_top. */
`timescale 1ns/1ps
module irqen_props
(
	// Clock, reset and bus
	input logic       clock_in,
	input logic       rst_in,
	input logic [7:0] addr_in,
	input logic [7:0] wdata_in,
	input logic       wr_in,
	input logic       rd_in,
	input logic [7:0] rdata_out,
	// Events and outputs
	input logic       timer2_overflow_in,
	input logic       compare_channel3_in,
	input logic       ext_int0_req_in,
	input logic       ext_int0_irq_out,
	input logic       timer2_irq_out,
	input logic       ext6_flag_out,
	input logic       watchdog_restart_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	// Bus decodes
	wire en_wr = wr_in && addr_in == 8'ha8;
	wire rq_rd = rd_in && addr_in == 8'hc0;
	wdog_pulse_a: assert property (en_wr && wdata_in[6] |=>
		watchdog_restart_out) else $error("no restart pulse");
	wdt_reads_zero_a: assert property ($past(rd_in && addr_in == 8'ha8)
		|-> !rdata_out[6]) else $error("restart bit read");
	rd_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
		else $error("stray read data");
	req_low_a: assert property ($past(rq_rd) |-> rdata_out[4:0] == 5'h00)
		else $error("low flag bits set");
	ovf_set_a: assert property (timer2_overflow_in ##1 rq_rd |=>
		rdata_out[6]) else $error("overflow flag lost");
	ext6_set_a: assert property (compare_channel3_in |->
		##[1:2] ext6_flag_out) else $error("ext6 flag not set");
	gate_ext0_a: assert property (ext_int0_irq_out |->
		$past(ext_int0_req_in)) else $error("ext0 without request");
	global_off_a: assert property (en_wr && !wdata_in[7] ##1 !en_wr
		|=> !timer2_irq_out && !ext_int0_irq_out) else $error("global off");
	// Main scenarios
	cover property (timer2_irq_out);
	cover property (ext6_flag_out ##[1:16] !ext6_flag_out);
	cover property (watchdog_restart_out);
endmodule
bind irqen_top irqen_props u_props (.*);

// ===== verification/tb_irqen_top.sv
/* Self-checking bench of the request and enable block.
 Assumes the core model answers the external 6 flag. */
`timescale 1ns/1ps
module tb_irqen_top;
	logic clock_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, svc = 0;
	logic [7:0] addr_in = 0, wdata_in = 0;
	logic [3:0] dly = 0;
	logic ext_input_a_in = 1, timer2_reload_pin_in = 1;
	logic ext6_rising_sel_in = 0, compare_channel3_in = 0;
	logic timer2_overflow_in = 0, timer2_reload_pin_enable_in = 0;
	logic ext_int0_req_in = 0, timer0_req_in = 0, ext_int1_req_in = 0;
	logic timer1_req_in = 0, serial_req_in = 0;
	wire [7:0] rdata_out;
	wire ext_int0_irq_out, timer0_irq_out, ext_int1_irq_out, timer1_irq_out;
	wire serial_irq_out, timer2_irq_out, ext6_flag_out, ext6_ack_in;
	wire watchdog_restart_out, timer2_reload_out;
	int num_errors = 0, samples_checked = 0, i;
	// Clock and instances
	always #2 clock_in = ~clock_in;
	irqen_top DUT (.*);
	irqen_core_model core (.clock_in, .rst_in, .service_en_in(svc),
		.delay_in(dly), .ext6_flag_in(ext6_flag_out), .ext6_ack_out(ext6_ack_in));
	task cyc(int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	task chk(logic [7:0] got, logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// One bus write or read cycle
	task acc(logic w, logic [7:0] a, logic [7:0] d);
		@(posedge clock_in);
		wr_in <= w;
		rd_in <= !w;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clock_in);
		wr_in <= 0;
		rd_in <= 0;
		#1;
	endtask
	task ovf(logic w);
		@(posedge clock_in);
		timer2_overflow_in <= 1;
		wr_in <= w;
		addr_in <= 8'hc0;
		wdata_in <= 0;
		@(posedge clock_in);
		timer2_overflow_in <= 0;
		wr_in <= 0;
	endtask
	task t_reset;
		acc(0, 8'hc0, 0); chk(rdata_out, 0);
		acc(0, 8'ha8, 0); chk(rdata_out, 0);
		acc(1, 8'h55, 8'hff); acc(0, 8'h55, 0); chk(rdata_out, 0);
		$display("reset test done");
	endtask
	task t_ovf;
		ovf(0); acc(0, 8'hc0, 0); chk(rdata_out, 8'h40);
		acc(1, 8'ha8, 8'ha0); cyc(1); chk(timer2_irq_out, 1);
		acc(1, 8'ha8, 8'h80); cyc(1); chk(timer2_irq_out, 0);
		ovf(1); acc(0, 8'hc0, 0); chk(rdata_out, 8'h40);
		acc(1, 8'hc0, 0); acc(0, 8'hc0, 0); chk(rdata_out, 0);
		$display("overflow test done");
	endtask
	task t_gates;
		{ext_int0_req_in, timer0_req_in, ext_int1_req_in} <= 3'h7;
		{timer1_req_in, serial_req_in} <= 2'h3;
		for (i = 0; i < 5; i++)
		begin
			acc(1, 8'ha8, 8'h80 | (8'h01 << i));
			cyc(1);
			chk({serial_irq_out, timer1_irq_out, ext_int1_irq_out, timer0_irq_out,
				ext_int0_irq_out}, 8'h01 << i);
		end
		acc(1, 8'ha8, 8'h1f); cyc(1); chk(serial_irq_out, 0);
		$display("gate test done");
	endtask
	// Falling reload edge, counting reload pulses while the pin is low
	task fall(logic en);
		int n;
		n = 0;
		@(posedge clock_in);
		timer2_reload_pin_in <= 0;
		repeat (8)
		begin
			cyc(1);
			n += timer2_reload_out;
		end
		timer2_reload_pin_in <= 1;
		cyc(2);
		chk(n, en);
	endtask
	task t_reload;
		fall(0); acc(0, 8'hc0, 0); chk(rdata_out, 0);
		timer2_reload_pin_enable_in <= 1;
		fall(1); acc(0, 8'hc0, 0); chk(rdata_out, 8'h80);
		acc(1, 8'ha8, 8'ha0); cyc(1); chk(timer2_irq_out, 1);
		acc(1, 8'hc0, 0); cyc(1); chk(timer2_irq_out, 0);
		$display("reload test done");
	endtask
	task ext6(logic pin, logic [3:0] d);
		@(posedge clock_in);
		svc <= 0;
		dly <= d;
		compare_channel3_in <= !pin;
		ext_input_a_in <= !pin;
		@(posedge clock_in);
		compare_channel3_in <= 0;
		repeat (6) @(posedge clock_in);
		ext_input_a_in <= 1;
		cyc(0);
		chk(ext6_flag_out, !(pin && ext6_rising_sel_in));
		cyc(6);
		acc(0, 8'hc0, 0); chk(rdata_out, 8'h20);
		@(posedge clock_in);
		svc <= 1;
		for (i = 0; i < 30 && ext6_flag_out !== 0; i++)
			cyc(1);
		chk(ext6_flag_out, 0);
		// A flag that never clears ends the run
		if (ext6_flag_out !== 0)
			give_verdict;
	endtask
	task t_ext6;
		ext6(0, 4'h0);
		ext6(1, 4'h9);
		// Rising edge selected: only the return to high sets the flag
		ext6_rising_sel_in <= 1;
		cyc(4);
		ext6(1, 4'h2);
		ext6_rising_sel_in <= 0;
		cyc(4);
		$display("ext6 test done");
	endtask
	task t_wdt;
		acc(1, 8'ha8, 8'h40); chk(watchdog_restart_out, 1);
		acc(0, 8'ha8, 0); chk(rdata_out, 0);
		$display("watchdog test done");
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (20) @(posedge clock_in);
		rst_in <= 0;
		t_reset;
		t_ovf;
		t_gates;
		t_reload;
		t_ext6;
		t_wdt;
		give_verdict;
	end
	// Hang limit
	initial
	begin
		#100000;
		num_errors++;
		give_verdict;
	end
endmodule
